// File: verilog/quad_phase_regs.svh
`ifndef QUAD_PHASE_REGS_SVH
`define QUAD_PHASE_REGS_SVH
`define PHASE_COUNT     3'h4
`define PC_WIDTH        11
`define INSN_WIDTH      12
`define PC_RESET_VALUE  11'h7FF
`define NOP_WORD        12'h000
`endif

// File: verilog/quad_phase_pkg.sv
package quad_phase_pkg;
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_e;
  typedef logic [10:0] pc_t;
  typedef logic [11:0] insn_t;
endpackage

// File: verilog/phase_divider.sv
`timescale 1ns/100ps
`default_nettype none
module phase_divider (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  output var  quad_phase_pkg::phase_e phase,
  output logic                       cycleRateOut
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= quad_phase_pkg::PH_ONE;
    end else begin
      case (phase)
        quad_phase_pkg::PH_ONE:   phase <= quad_phase_pkg::PH_TWO;
        quad_phase_pkg::PH_TWO:   phase <= quad_phase_pkg::PH_THREE;
        quad_phase_pkg::PH_THREE: phase <= quad_phase_pkg::PH_FOUR;
        default:                  phase <= quad_phase_pkg::PH_ONE;
      endcase
    end
  end
  // High in phases two and three here; the pin flop downstream adds one cycle,
  // so the pin itself is high in phases three and four
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleRateOut <= 1'b0;
    end else begin
      cycleRateOut <= (phase == quad_phase_pkg::PH_ONE) || (phase == quad_phase_pkg::PH_TWO);
    end
  end
endmodule
`default_nettype wire

// File: verilog/flush_tracker.sv
`timescale 1ns/100ps
`default_nettype none
module flush_tracker (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic cycleEnd,
  input  wire logic branchTaken,
  output logic      flushActive
);
  // Marks the one instruction cycle that follows a taken branch, and the first cycle after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flushActive <= 1'b1;
    end else if (cycleEnd) begin
      flushActive <= branchTaken;
    end
  end
endmodule
`default_nettype wire

// File: verilog/quad_phase_fetch_execute_sequencer.sv
// Notes on behaviour
// - Input clock divided by four gives four non-overlapping phases per cycle.
// - Program counter increments in phase one, starting the next fetch.
// - Fetched word is captured from program memory in phase four of fetch.
// - Captured instruction is decoded and executed over the following cycle.
// - Fetch of the next instruction overlaps execution of the current one.
// - Instructions that change the program counter take two cycles.
// - Instruction latch presents the word from phase one of execution.
// - Data-memory operand read happens in phase two of execution.
// - Data-memory result write happens in phase four of execution.
// - In resistor-capacitor mode the cycle-rate output runs at quarter clock.
// - Device is held in reset while the active-low external reset is low.
`include "quad_phase_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module quad_phase_fetch_execute_sequencer (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 external_reset_n,
  input  wire logic                 resistor_capacitor_oscillator_mode,
  input  wire logic [11:0]          progData,
  input  wire logic                 branchRequest,
  input  wire logic [10:0]          branchTarget,
  output logic [10:0]               progAddr,
  output logic [11:0]               instruction_latch,
  output logic                      insnValid,
  output logic                      phase_one,
  output logic                      phase_two,
  output logic                      phase_three,
  output logic                      phase_four,
  output logic                      operandReadStrobe,
  output logic                      resultWriteStrobe,
  output logic                      cycle_rate_out_pin
);
  quad_phase_pkg::phase_e phase;
  logic                   rateClk;
  logic                   flushActive;
  logic                   branchTaken;
  logic                   resetAll_n;
  logic [11:0]            fetch_q;
  logic [10:0]            pc_q;

  assign resetAll_n = rst_n & external_reset_n;

  phase_divider u_div (
    .ref_clk      (ref_clk),
    .rst_n        (resetAll_n),
    .phase        (phase),
    .cycleRateOut (rateClk)
  );

  // Branch decision is taken only from a real, non-flushed instruction
  assign branchTaken = branchRequest && !flushActive;

  flush_tracker u_flush (
    .ref_clk     (ref_clk),
    .rst_n       (resetAll_n),
    .cycleEnd    (phase == quad_phase_pkg::PH_FOUR),
    .branchTaken (branchTaken),
    .flushActive (flushActive)
  );

  assign phase_one   = (phase == quad_phase_pkg::PH_ONE);
  assign phase_two   = (phase == quad_phase_pkg::PH_TWO);
  assign phase_three = (phase == quad_phase_pkg::PH_THREE);
  assign phase_four  = (phase == quad_phase_pkg::PH_FOUR);

  // Program counter: increments at the end of phase one; a branch loads the
  // target in phase four so the next fetch starts from it.
  always_ff @(posedge ref_clk or negedge resetAll_n) begin
    if (!resetAll_n) begin
      pc_q <= `PC_RESET_VALUE;
    end else if (phase_four && branchTaken) begin
      pc_q <= branchTarget;
    end else if (phase_one) begin
      pc_q <= pc_q + 11'h001;
    end
  end
  assign progAddr = pc_q;

  // Capture the fetched word at the close of phase four
  always_ff @(posedge ref_clk or negedge resetAll_n) begin
    if (!resetAll_n) begin
      fetch_q <= `NOP_WORD;
    end else if (phase_four) begin
      fetch_q <= progData;
    end
  end

  // Latch moves into execution at the start of phase one; a discarded
  // prefetch is replaced by a no-op so no side effects reach memory.
  always_ff @(posedge ref_clk or negedge resetAll_n) begin
    if (!resetAll_n) begin
      instruction_latch <= `NOP_WORD;
      insnValid         <= 1'b0;
    end else if (phase_four) begin
      instruction_latch <= branchTaken ? `NOP_WORD : progData;
      insnValid         <= !branchTaken;
    end
  end

  assign operandReadStrobe = phase_two && insnValid && !flushActive;
  assign resultWriteStrobe = phase_four && insnValid && !flushActive;

  // Crystal modes leave the pin low; only RC mode shows the cycle rate
  always_ff @(posedge ref_clk or negedge resetAll_n) begin
    if (!resetAll_n) begin
      cycle_rate_out_pin <= 1'b0;
    end else begin
      cycle_rate_out_pin <= resistor_capacitor_oscillator_mode & rateClk;
    end
  end
endmodule
`default_nettype wire

// File: verification/qp_seq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module qp_seq_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        external_reset_n,
  input wire logic        resistor_capacitor_oscillator_mode,
  input wire logic        branchRequest,
  input wire logic        insnValid,
  input wire logic        phase_one,
  input wire logic        phase_two,
  input wire logic        phase_three,
  input wire logic        phase_four,
  input wire logic        operandReadStrobe,
  input wire logic        resultWriteStrobe,
  input wire logic        cycle_rate_out_pin,
  input wire logic [10:0] progAddr,
  input wire logic [10:0] branchTarget,
  input wire logic [11:0] instruction_latch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !external_reset_n);
  phase_order_a: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
    else $error("phase order");
  phase_hot_a: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
    else $error("phases overlap");
  pc_step_a: assert property (phase_one |=> progAddr == 11'($past(progAddr) + 11'h1))
    else $error("pc step");
  pc_hold_a: assert property (phase_two || phase_three |=> $stable(progAddr))
    else $error("pc moved");
  latch_hold_a: assert property (!phase_one |-> $stable(instruction_latch) && $stable(insnValid))
    else $error("latch moved");
  read_slot_a: assert property (operandReadStrobe == (phase_two && insnValid))
    else $error("rd");
  write_slot_a: assert property (resultWriteStrobe == (phase_four && insnValid))
    else $error("wr");
  branch_flush_a: assert property (phase_four && insnValid && branchRequest |=>
    progAddr == $past(branchTarget) ##0 !insnValid[*4] ##1 insnValid) else $error("flush");
  fetch_next_a: assert property (phase_four && !(insnValid && branchRequest) |=> insnValid)
    else $error("no overlap");
  rc_wave_a: assert property ($rose(cycle_rate_out_pin) |-> phase_three ##1 cycle_rate_out_pin
    ##1 !cycle_rate_out_pin) else $error("rc wave");
  cover property (phase_four && insnValid && branchRequest);
  cover property (phase_four && !insnValid && branchRequest);
  cover property ($rose(cycle_rate_out_pin));
endmodule
bind quad_phase_fetch_execute_sequencer qp_seq_chk u_chk (.*);
`default_nettype wire

// File: verification/clk_reset_src.sv
`timescale 1ns/100ps
`default_nettype none
module clk_reset_src (
  output logic      ref_clk,
  output logic      external_reset_n,
  input  wire logic holdReset
);
  initial ref_clk = 1'h0;
  always #20 ref_clk = ~ref_clk;
  assign external_reset_n = !holdReset;
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top;
  logic ref_clk, rst_n, external_reset_n, holdReset, resistor_capacitor_oscillator_mode;
  logic branchRequest, phase_one, phase_two, phase_three, phase_four, insnValid, expValid;
  logic operandReadStrobe, resultWriteStrobe, cycle_rate_out_pin;
  logic [11:0] progData, instruction_latch, expLatch;
  logic [10:0] branchTarget, progAddr, expPc;
  int          fails, tests_run;
  clk_reset_src u_src (.*);
  quad_phase_fetch_execute_sequencer u_dut (.*);
  function automatic logic [10:0] incPc(input logic [10:0] pc);
    return pc + 11'h1;
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    {rst_n, holdReset, resistor_capacitor_oscillator_mode, branchRequest} = '0;
    {progData, branchTarget} = '0;
    void'($urandom(8844));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'h1;
    for (int t = 0; t < 4; t++) begin
      if (t > 0) begin
        holdReset = 1'h1;
        resistor_capacitor_oscillator_mode = t[0];
        repeat (2) @(negedge ref_clk);
        `CHK("rst", {1'h1, 11'h7FF, 2'h0}, {phase_one, progAddr, insnValid, cycle_rate_out_pin})
        holdReset = 1'h0;
      end
      expPc = 11'h7FF;
      expValid = 1'h0;
      repeat (200) begin
        if (phase_one) begin
          `CHK("pc", expPc, progAddr)
          `CHK("valid", expValid, insnValid)
          if (expValid) `CHK("latch", expLatch, instruction_latch)
          expPc = incPc(expPc);
        end
        `CHK("rd", phase_two && expValid, operandReadStrobe)
        `CHK("wr", phase_four && expValid, resultWriteStrobe)
        `CHK("rc", resistor_capacitor_oscillator_mode && (phase_three || phase_four), cycle_rate_out_pin)
        branchRequest = 1'h0;
        if (phase_four) begin
          progData = 12'($urandom);
          branchTarget = 11'($urandom);
          // Last run branches every cycle, so taken and ignored requests alternate
          branchRequest = (t == 3) || ($urandom % 4 == 0);
          expLatch = progData;
          if (branchRequest && expValid) begin
            expPc = branchTarget;
            expValid = 1'h0;
          end else expValid = 1'h1;
        end
        @(negedge ref_clk);
      end
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule
`default_nettype wire
